//--- design/osc_pkg.sv
// Package: register map, field positions, reset values and timing counts for the oscillator control
package osc_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_CRYSTAL_CTRL = 12'h000;
  localparam logic [11:0] ADDR_FAST_CTRL = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  // Crystal control fields
  localparam int XC_ENABLE_BIT = 1;
  localparam int XC_REQ_GATE_BIT = 7;
  localparam int XC_GAIN_LSB = 8;
  localparam int XC_AGC_BIT = 11;
  localparam int XC_STARTUP_LSB = 12;
  localparam logic [15:0] XC_RESET = 16'h0000;
  // Fast oscillator control fields
  localparam int FC_ENABLE_BIT = 1;
  localparam int FC_STANDBY_BIT = 6;
  localparam int FC_REQ_GATE_BIT = 7;
  localparam logic [7:0] FC_RESET = 8'h82;
  // Status fields
  localparam int ST_XRDY_BIT = 0;
  localparam int ST_XRUN_BIT = 1;
  localparam int ST_FRUN_BIT = 2;
  // Startup timing
  localparam logic [3:0] STARTUP_MIN_CODE = 4'h6;
  localparam logic [3:0] PRE_XTAL_CYCLES = 4'h3;
  localparam int SLOW_CNT_W = 16;
  localparam logic [2:0] GAIN_MAX_CODE = 3'h4;
  // Amplitude control: bus clock cycles between gain steps, less one
  localparam logic [7:0] AGC_PERIOD = 8'hFF;
endpackage : osc_pkg

//--- design/osc_agc_if.sv
// Interface: amplitude gain control request and answer between top and regulator
`timescale 1ns/1ps
`default_nettype none
interface osc_agc_if;
  logic active;
  logic [2:0] base_gain;
  logic amp_low;
  logic amp_high;
  logic [2:0] gain;
  modport ctrl (output active, output base_gain, output amp_low, output amp_high, input gain);
  modport reg_side (input active, input base_gain, input amp_low, input amp_high, output gain);
endinterface : osc_agc_if
`default_nettype wire

//--- design/osc_agc.sv
// Automatic amplitude gain regulator for the crystal oscillator
`timescale 1ns/1ps
`default_nettype none
module osc_agc (
  input wire logic pclk,
  input wire logic presetn,
  osc_agc_if.reg_side agc
);
  typedef struct packed {
    logic [2:0] gain;
    logic [7:0] tick;
  } osc_agc_state_t;
  osc_agc_state_t st;
  osc_agc_state_t next_st;

  // Track amplitude detector while active, else follow programmed gain
  always_comb begin
    next_st = st;
    if (!agc.active) begin
      next_st.gain = agc.base_gain;
      next_st.tick = 8'h00;
    end else if (st.tick == osc_pkg::AGC_PERIOD) begin
      next_st.tick = 8'h00;
      if (agc.amp_low && st.gain < osc_pkg::GAIN_MAX_CODE) begin
        next_st.gain = st.gain + 3'h1;
      end else if (agc.amp_high && st.gain != 3'h0) begin
        next_st.gain = st.gain - 3'h1;
      end
    end else begin
      next_st.tick = st.tick + 8'h01;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign agc.gain = st.gain;
endmodule : osc_agc
`default_nettype wire

//--- design/osc_startup.sv
// Crystal start-up timer: three crystal cycles then a selectable number of slow clock cycles
`timescale 1ns/1ps
`default_nettype none
module osc_startup (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [3:0] startup_code,
  input wire logic xtal_edge,
  input wire logic slow_edge,
  output logic ready
);
  typedef enum logic [2:0] {
    SU_IDLE = 3'b001,
    SU_XTAL = 3'b010,
    SU_SLOW = 3'b100
  } osc_su_phase_t;
  typedef struct packed {
    osc_su_phase_t phase;
    logic [3:0] xcnt;
    logic [osc_pkg::SLOW_CNT_W-1:0] scnt;
    logic ready;
  } osc_su_state_t;
  osc_su_state_t st;
  osc_su_state_t next_st;
  logic [osc_pkg::SLOW_CNT_W-1:0] target;
  logic [3:0] code;

  // Codes below the minimum count as the minimum; count doubles per step
  always_comb begin
    code = (startup_code < osc_pkg::STARTUP_MIN_CODE) ? osc_pkg::STARTUP_MIN_CODE : startup_code;
    target = 16'(17'h00001 << code);
  end

  // Sequencer
  always_comb begin
    next_st = st;
    if (!run) begin
      next_st.phase = SU_IDLE;
      next_st.ready = 1'b0;
      next_st.xcnt = 4'h0;
      next_st.scnt = '0;
    end else begin
      unique case (st.phase)
        SU_IDLE: begin
          if (!st.ready) begin
            next_st.phase = SU_XTAL;
          end
        end
        SU_XTAL: begin
          if (xtal_edge) begin
            next_st.xcnt = st.xcnt + 4'h1;
            if (st.xcnt + 4'h1 == osc_pkg::PRE_XTAL_CYCLES) begin
              next_st.phase = SU_SLOW;
            end
          end
        end
        SU_SLOW: begin
          if (slow_edge) begin
            next_st.scnt = st.scnt + 16'h0001;
            if (st.scnt + 16'h0001 == target) begin
              next_st.phase = SU_IDLE;
              next_st.ready = 1'b1;
            end
          end
        end
        default: next_st.phase = SU_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{phase: SU_IDLE, xcnt: 4'h0, scnt: '0, ready: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign ready = st.ready;
endmodule : osc_startup
`default_nettype wire

//--- design/osc_ctrl.sv
// Oscillator control top: APB registers, crystal start-up and gain, fast oscillator gating
// Behaviour
// [RL1] After enable wait three crystal cycles, then 64..32768 slow cycles by code.
// [RL2] Software sets auto gain only after crystal ready flag shows settled.
// [RL3] Auto gain bit 1 adjusts gain while running; 0 disables adjustment.
// [RL4] Three-bit gain field selects gain; codes 5 to 7 reserved.
// [RL5] Software programs gain field properly even with auto gain on.
// [RL6] On-demand set: oscillator runs only while some peripheral requests it.
// [RL7] On-demand set and no request: oscillator held disabled.
// [RL8] On-demand clear: oscillator runs whenever enabled, ignoring requests.
// [RL9] On-demand gating stays in force during standby.
// [RL10] Run-in-standby clear: fast oscillator off in standby without request.
// [RL11] Run-in-standby set: not stopped in standby; on-demand still applies.
// [RL12] Enable bit switches oscillator; fast control resets enable=1, on-demand=1.
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xtal_clk_in,
  input wire logic slow_clk_in,
  input wire logic xtal_req,
  input wire logic fast_req,
  input wire logic standby,
  input wire logic amp_low,
  input wire logic amp_high,
  output logic xtal_run,
  output logic [2:0] xtal_gain,
  output logic xtal_ready,
  output logic fast_run
);
  typedef struct packed {
    logic [15:0] xctrl;
    logic [7:0] fctrl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] xclk_sync;
    logic [1:0] sclk_sync;
    logic [1:0] xreq_sync;
    logic [1:0] freq_sync;
    logic [1:0] stby_sync;
    logic [1:0] alow_sync;
    logic [1:0] ahigh_sync;
    logic xclk_prev;
    logic sclk_prev;
    logic xtal_run;
    logic [2:0] xtal_gain;
    logic xtal_ready;
    logic fast_run;
  } osc_top_state_t;
  osc_top_state_t st;
  osc_top_state_t next_st;
  logic su_ready;
  logic access;
  logic [31:0] rd_word;
  osc_agc_if agc_bus ();

  // Start-up timer for the crystal
  osc_startup u_startup (
    .pclk(pclk),
    .presetn(presetn),
    .run(st.xtal_run),
    .startup_code(st.xctrl[osc_pkg::XC_STARTUP_LSB +: 4]),
    .xtal_edge(st.xclk_sync[1] & ~st.xclk_prev),
    .slow_edge(st.sclk_sync[1] & ~st.sclk_prev),
    .ready(su_ready)
  );

  // Amplitude regulator runs only once settled and auto gain is on
  assign agc_bus.active = st.xctrl[osc_pkg::XC_AGC_BIT] & st.xtal_run & su_ready; // RL3
  assign agc_bus.base_gain = st.xctrl[osc_pkg::XC_GAIN_LSB +: 3]; // RL4 RL5
  assign agc_bus.amp_low = st.alow_sync[1];
  assign agc_bus.amp_high = st.ahigh_sync[1];

  osc_agc u_agc (
    .pclk(pclk),
    .presetn(presetn),
    .agc(agc_bus.reg_side)
  );

  assign access = psel & penable & ~st.pready;

  // Read multiplexer
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      osc_pkg::ADDR_CRYSTAL_CTRL: rd_word = {16'h0000, st.xctrl};
      osc_pkg::ADDR_FAST_CTRL: rd_word = {24'h000000, st.fctrl};
      osc_pkg::ADDR_STATUS: begin
        rd_word[osc_pkg::ST_XRDY_BIT] = st.xtal_ready; // RL2
        rd_word[osc_pkg::ST_XRUN_BIT] = st.xtal_run;
        rd_word[osc_pkg::ST_FRUN_BIT] = st.fast_run;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Next-state logic
  always_comb begin
    next_st = st;
    // Two-flop synchronisers for pins
    next_st.xclk_sync = {st.xclk_sync[0], xtal_clk_in};
    next_st.sclk_sync = {st.sclk_sync[0], slow_clk_in};
    next_st.xreq_sync = {st.xreq_sync[0], xtal_req};
    next_st.freq_sync = {st.freq_sync[0], fast_req};
    next_st.stby_sync = {st.stby_sync[0], standby};
    next_st.alow_sync = {st.alow_sync[0], amp_low};
    next_st.ahigh_sync = {st.ahigh_sync[0], amp_high};
    next_st.xclk_prev = st.xclk_sync[1];
    next_st.sclk_prev = st.sclk_sync[1];
    // APB: one wait state, answer in the second access cycle
    next_st.pready = access;
    next_st.pslverr = 1'b0;
    if (access) begin
      next_st.pslverr = (paddr != osc_pkg::ADDR_CRYSTAL_CTRL) && (paddr != osc_pkg::ADDR_FAST_CTRL)
                        && (paddr != osc_pkg::ADDR_STATUS);
      next_st.prdata = pwrite ? 32'h0000_0000 : rd_word;
      if (pwrite && paddr == osc_pkg::ADDR_CRYSTAL_CTRL) begin
        if (pstrb[0]) begin
          next_st.xctrl[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
          next_st.xctrl[15:8] = pwdata[15:8];
        end
      end
      if (pwrite && paddr == osc_pkg::ADDR_FAST_CTRL && pstrb[0]) begin
        next_st.fctrl = pwdata[7:0];
      end
    end
    // Crystal run: enable, with on-demand gating
    next_st.xtal_run = st.xctrl[osc_pkg::XC_ENABLE_BIT]
                       & (~st.xctrl[osc_pkg::XC_REQ_GATE_BIT] | st.xreq_sync[1]); // RL6 RL7 RL8 RL12
    next_st.xtal_ready = su_ready & st.xtal_run; // RL1
    next_st.xtal_gain = agc_bus.gain; // RL3 RL4
    // Fast oscillator run: on-demand gating, standby stop without request unless kept running
    if (!st.fctrl[osc_pkg::FC_ENABLE_BIT]) begin
      next_st.fast_run = 1'b0; // RL12
    end else if (st.fctrl[osc_pkg::FC_REQ_GATE_BIT]) begin
      next_st.fast_run = st.freq_sync[1]; // RL6 RL7 RL9 RL10 RL11
    end else if (st.stby_sync[1] && !st.fctrl[osc_pkg::FC_STANDBY_BIT]) begin
      next_st.fast_run = st.freq_sync[1]; // RL10
    end else begin
      next_st.fast_run = 1'b1; // RL8 RL11
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{xctrl: osc_pkg::XC_RESET, fctrl: osc_pkg::FC_RESET, default: '0}; // RL12
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign xtal_run = st.xtal_run;
  assign xtal_gain = st.xtal_gain;
  assign xtal_ready = st.xtal_ready;
  assign fast_run = st.fast_run;
endmodule : osc_ctrl
`default_nettype wire

//--- verification/osc_periph_model.sv
// Partner model: clock-requesting peripherals plus crystal and slow clock sources
`timescale 1ns/1ps
`default_nettype none
module osc_periph_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic xtal_run,
  input wire logic want_x,
  input wire logic want_f,
  output logic xtal_req,
  output logic fast_req,
  output logic xtal_clk_in,
  output logic slow_clk_in
);
  // Crystal only oscillates while the block enables it, else rests low
  initial begin
    xtal_clk_in = 1'b0;
    forever #43 xtal_clk_in = xtal_run ? ~xtal_clk_in : 1'b0;
  end
  // Slow clock runs free, far below the bus clock
  initial begin
    slow_clk_in = 1'b0;
    forever #80 slow_clk_in = ~slow_clk_in;
  end
  // Request levels move just after a bus clock edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_req <= 1'b0;
      fast_req <= 1'b0;
    end else begin
      xtal_req <= want_x;
      fast_req <= want_f;
    end
  end
endmodule : osc_periph_model
`default_nettype wire

//--- verification/osc_ctrl_checker.sv
// Checker: gating and start-up properties seen at the oscillator control ports
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic slow_clk_in,
  input wire logic xtal_req,
  input wire logic fast_req,
  input wire logic standby,
  input wire logic xtal_run,
  input wire logic xtal_ready,
  input wire logic fast_run
);
  logic [7:0] fc;
  logic [15:0] xc;
  logic [15:0] slow_cnt;
  logic slow_q;
  logic wr;
  logic exp_f;
  logic exp_x;
  // Expected enables from shadow registers and requests
  assign wr = psel && penable && pready && pwrite;
  assign exp_f = fc[1] && ((fc[7] || (standby && !fc[6])) ? fast_req : 1'b1);
  assign exp_x = xc[1] && (!xc[7] || xtal_req);
  // Shadows update when a write completes; slow edges counted while crystal runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fc <= osc_pkg::FC_RESET;
      xc <= osc_pkg::XC_RESET;
      slow_q <= 1'b0;
      slow_cnt <= 16'h0000;
    end else begin
      if (wr && paddr == osc_pkg::ADDR_FAST_CTRL) fc <= pwdata[7:0];
      if (wr && paddr == osc_pkg::ADDR_CRYSTAL_CTRL) xc <= pwdata[15:0];
      slow_q <= slow_clk_in;
      if (!xtal_run) slow_cnt <= 16'h0000;
      else if (slow_clk_in && !slow_q && slow_cnt != 16'hFFFF) slow_cnt <= slow_cnt + 16'h0001;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_fast_req; $stable(exp_f)[*4] ##0 (fc[1] && fc[7] && fast_req) |-> fast_run; endproperty
  a_fast_req: assert property (p_fast_req) else $error("fast clock off while requested");
  property p_fast_idle; $stable(exp_f)[*4] ##0 (fc[7] && !fast_req) |-> !fast_run; endproperty
  a_fast_idle: assert property (p_fast_idle) else $error("fast clock on without request");
  property p_fast_always; $stable(exp_f)[*4] ##0 (fc[1] && !fc[7] && !standby) |-> fast_run; endproperty
  a_fast_always: assert property (p_fast_always) else $error("fast clock off while enabled");
  property p_stdby_od; $stable(exp_f)[*4] ##0 (standby && fc[1] && fc[7]) |-> fast_run == fast_req; endproperty
  a_stdby_od: assert property (p_stdby_od) else $error("standby request gating lost");
  property p_stdby_off; $stable(exp_f)[*4] ##0 (standby && fc[1] && !fc[6]) |-> fast_run == fast_req; endproperty
  a_stdby_off: assert property (p_stdby_off) else $error("fast clock runs idle in standby");
  property p_stdby_keep; $stable(exp_f)[*4] ##0 (standby && fc[1] && fc[6] && !fc[7]) |-> fast_run; endproperty
  a_stdby_keep: assert property (p_stdby_keep) else $error("fast clock stopped in standby");
  property p_fast_off; (!fc[1] && !$past(fc[1], 2)) |-> !fast_run; endproperty
  a_fast_off: assert property (p_fast_off) else $error("fast clock on while disabled");
  property p_xtal_gate; $stable(exp_x)[*4] |-> xtal_run == exp_x; endproperty
  a_xtal_gate: assert property (p_xtal_gate) else $error("crystal enable wrong");
  property p_startup; $rose(xtal_ready) |-> slow_cnt >= 16'h0040; endproperty
  a_startup: assert property (p_startup) else $error("crystal ready too early");
  property p_ready_off; !xtal_run |=> !xtal_ready; endproperty
  a_ready_off: assert property (p_ready_off) else $error("crystal ready while stopped");
endmodule : osc_ctrl_checker
bind osc_ctrl osc_ctrl_checker osc_ctrl_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .slow_clk_in(slow_clk_in), .xtal_req(xtal_req), .fast_req(fast_req),
  .standby(standby), .xtal_run(xtal_run), .xtal_ready(xtal_ready), .fast_run(fast_run)
);
`default_nettype wire

//--- verification/oscillator_control_bench.sv
// Bench: register reset values, oscillator gating, crystal start-up and auto gain
`timescale 1ns/1ps
`default_nettype none
module oscillator_control_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic standby = 1'b0, amp_low = 1'b0, amp_high = 1'b0, want_x = 1'b0, want_f = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic [2:0] xtal_gain;
  logic pready, pslverr, xtal_clk_in, slow_clk_in, xtal_req, fast_req, xtal_run, xtal_ready, fast_run;
  int fail_count = 0;
  int checked = 0;
  int seed = 60347;
  logic [32:0] exp_q[$];
  always #5 pclk = ~pclk;
  osc_ctrl osc_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xtal_clk_in(xtal_clk_in), .slow_clk_in(slow_clk_in), .xtal_req(xtal_req), .fast_req(fast_req),
    .standby(standby), .amp_low(amp_low), .amp_high(amp_high), .xtal_run(xtal_run),
    .xtal_gain(xtal_gain), .xtal_ready(xtal_ready), .fast_run(fast_run)
  );
  osc_periph_model osc_periph_model_inst (
    .pclk(pclk), .presetn(presetn), .xtal_run(xtal_run), .want_x(want_x), .want_f(want_f),
    .xtal_req(xtal_req), .fast_req(fast_req), .xtal_clk_in(xtal_clk_in), .slow_clk_in(slow_clk_in)
  );
  task automatic compare_read(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t read %h expected %h", $time, got, exp);
    end
  endtask : compare_read
  task automatic compare_pin(input logic [4:0] got, input logic [4:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t pins %b expected %b", $time, got, exp);
    end
  endtask : compare_pin
  // One APB transfer; a read notes its expected {pslverr, prdata}
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!wr) exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Hold the access phase until ready; only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    penable <= 1'b0;
    psel <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  // Read results are matched against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      compare_read({pslverr, prdata}, exp_q.size() > 0 ? exp_q.pop_front() : 33'h1FFFFFFFF);
    end
  end
  initial begin
    #200000;
    fail_count++;
    $display("mismatch %0t watchdog expired", $time);
    final_report();
  end
  initial begin
    logic [4:0] c;
    logic [2:0] g;
    logic exp_f;
    int n;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, osc_pkg::ADDR_FAST_CTRL, 32'h0, {25'h0, osc_pkg::FC_RESET});
    apb(1'b0, osc_pkg::ADDR_CRYSTAL_CTRL, 32'h0, 33'h0);
    apb(1'b0, 12'h00C, 32'h0, 33'h100000000);
    // Every enable, on-demand, keep, standby and request combination
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      apb(1'b1, osc_pkg::ADDR_FAST_CTRL, {24'h0, c[2], c[1], 4'h0, c[0], 1'b0}, 33'h0);
      standby <= c[3];
      want_f <= c[4];
      repeat (6) @(posedge pclk);
      exp_f = c[0] && ((c[2] || (c[3] && !c[1])) ? c[4] : 1'b1);
      compare_pin({4'h0, fast_run}, {4'h0, exp_f});
    end
    g = 3'($unsigned($random(seed)) % 5);
    apb(1'b1, osc_pkg::ADDR_CRYSTAL_CTRL, {16'h0, 4'h6, 1'b0, g, 8'h82}, 33'h0);
    repeat (6) @(posedge pclk);
    compare_pin({xtal_ready, xtal_run, 3'h0}, 5'h00);
    want_x <= 1'b1;
    n = 0;
    while (xtal_ready !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    compare_pin({xtal_ready, xtal_run, xtal_gain}, {2'b11, g});
    compare_pin({4'h0, n > 1000}, 5'h01);
    apb(1'b0, osc_pkg::ADDR_STATUS, 32'h0, 33'h7);
    amp_low <= 1'b1;
    apb(1'b1, osc_pkg::ADDR_CRYSTAL_CTRL, {16'h0, 4'h6, 1'b1, g, 8'h82}, 33'h0);
    repeat (1400) @(posedge pclk);
    compare_pin({2'h0, xtal_gain}, 5'h04);
    amp_low <= 1'b0;
    amp_high <= 1'b1;
    repeat (1400) @(posedge pclk);
    compare_pin({2'h0, xtal_gain}, 5'h00);
    apb(1'b1, osc_pkg::ADDR_CRYSTAL_CTRL, {16'h0, 4'h6, 1'b0, g, 8'h82}, 33'h0);
    repeat (6) @(posedge pclk);
    compare_pin({2'h0, xtal_gain}, {2'h0, g});
    apb(1'b1, osc_pkg::ADDR_CRYSTAL_CTRL, {16'h0, 4'h6, 1'b0, g, 8'h80}, 33'h0);
    repeat (6) @(posedge pclk);
    compare_pin({xtal_ready, xtal_run, 3'h0}, 5'h00);
    // Restart with the next code: twice the slow cycles, 16 bus cycles each
    apb(1'b1, osc_pkg::ADDR_CRYSTAL_CTRL, {16'h0, 4'h7, 1'b0, g, 8'h82}, 33'h0);
    n = 0;
    while (xtal_ready !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    compare_pin({3'h0, n > 2000, n < 2200}, 5'h03);
    final_report();
  end
endmodule : oscillator_control_bench
`default_nettype wire
